// ===== rtl/csf_status_flags.sv
// Operation
// RULE_01: Carry set on carry or borrow at top.
// RULE_02: Zero set when result is zero.
// RULE_03: Sign copies result bit 7.
// RULE_04: Overflow set when signed range exceeded.
// RULE_05: Decimal flag: zero add, one subtract.
// RULE_06: Half-carry set on bit 3 carry/borrow.
// RULE_07: Fast status reads one during fast service.
// RULE_08: Fast status zero during return; read-only.
// RULE_09: Bank bit selects bank, software writable.
// RULE_10: Reached only by direct register addressing.
// RULE_11: Reset clears fast and bank bits.
// RULE_12: Software write wins over flag update.
`timescale 1ns/1ps
`default_nettype none
module csf_status_flags (
   input wire logic CLK, // 40 MHz CPU clock.
   input wire logic RST_N, // Asynchronous reset, active low.
   input wire logic [1:0] OP_KIND, // Operation kind, csf_op_t coding.
   input wire logic [7:0] OP_A, // First operand.
   input wire logic [7:0] OP_B, // Second operand.
   input wire logic OP_CARRY_IN, // Carry or borrow in for add or subtract with carry.
   input wire logic OP_VALID, // One-cycle strobe: apply the operation result to the flags.
   input wire logic FAST_ENTER, // Pulse: fast interrupt service starts.
   input wire logic FAST_RETURN, // Pulse: interrupt return begins.
   input wire logic REG_WR, // Register write strobe.
   input wire logic REG_RD, // Register read strobe.
   input wire logic REG_DIRECT, // High when the access uses direct register addressing.
   input wire logic [7:0] REG_ADDR, // Register address.
   input wire logic [7:0] REG_WDATA, // Register write data.
   output logic [7:0] REG_RDATA, // Read data, registered.
   output logic REG_HIT, // Read data valid, registered pulse.
   output logic [7:0] RESULT, // Operation result, registered.
   output logic BANK_SEL // Selected register bank, registered.
);

   // Current flag register, one flop group per concern so each has a single driver.
   logic [7:2] arith_reg; // Result flags, carry down to half-carry.
   logic fast_reg; // Fast service status, read-only to software.
   logic bank_reg; // Register bank select.
   logic [7:0] flags_reg; // Whole register as software sees it.
   logic [7:0] flags_next;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] res;
   logic sel_wr;
   logic sel_rd;
   csf_pkg::csf_op_t op;

   // Only a direct access to the exact address reaches the register.
   // RULE_10: direct addressing decode
   function automatic logic hit(input logic direct, input logic [7:0] addr);
      hit = direct && (addr == csf_pkg::CPU_CONDITION_STATE_ADDR);
   endfunction

   assign sel_wr = REG_WR && hit(REG_DIRECT, REG_ADDR);
   assign sel_rd = REG_RD && hit(REG_DIRECT, REG_ADDR);
   assign op = csf_pkg::csf_op_t'(OP_KIND);
   // The three flop groups are joined here so reads and checks see one register.
   assign flags_reg = {arith_reg, fast_reg, bank_reg};

   // Arithmetic is done with one extra bit so the carry and borrow fall out of the top.
   always_comb begin
      sum9 = 9'h000;
      sum5 = 5'h00;
      res = OP_A & OP_B;
      case (op)
         csf_pkg::CSF_OP_ADD: begin
            sum9 = {1'b0, OP_A} + {1'b0, OP_B} + {8'h00, OP_CARRY_IN};
            sum5 = {1'b0, OP_A[3:0]} + {1'b0, OP_B[3:0]} + {4'h0, OP_CARRY_IN};
            res = sum9[7:0];
         end
         csf_pkg::CSF_OP_SUB: begin
            sum9 = {1'b0, OP_A} - {1'b0, OP_B} - {8'h00, OP_CARRY_IN};
            sum5 = {1'b0, OP_A[3:0]} - {1'b0, OP_B[3:0]} - {4'h0, OP_CARRY_IN};
            res = sum9[7:0];
         end
         default: begin
            res = OP_A & OP_B;
         end
      endcase
   end

   // Next flag value; logic operations leave carry, half-carry and decimal alone.
   always_comb begin
      flags_next = flags_reg;
      // RULE_02: zero detect
      flags_next[csf_pkg::ZERO_BIT] = (res == 8'h00);
      // RULE_03: sign copy
      flags_next[csf_pkg::SIGN_BIT] = res[7];
      flags_next[csf_pkg::OVFL_BIT] = 1'b0;
      if (op == csf_pkg::CSF_OP_ADD) begin
         // RULE_01: carry out
         flags_next[csf_pkg::CARRY_BIT] = sum9[8];
         // RULE_04: signed overflow add
         flags_next[csf_pkg::OVFL_BIT] = (OP_A[7] == OP_B[7]) && (res[7] != OP_A[7]);
         // RULE_05: add marks zero
         flags_next[csf_pkg::DEC_BIT] = 1'b0;
         // RULE_06: half carry
         flags_next[csf_pkg::HALF_BIT] = sum5[4];
      end else if (op == csf_pkg::CSF_OP_SUB) begin
         // RULE_01: borrow out
         flags_next[csf_pkg::CARRY_BIT] = sum9[8];
         // RULE_04: signed overflow subtract
         flags_next[csf_pkg::OVFL_BIT] = (OP_A[7] != OP_B[7]) && (res[7] != OP_A[7]);
         // RULE_05: subtract marks one
         flags_next[csf_pkg::DEC_BIT] = 1'b1;
         // RULE_06: half borrow
         flags_next[csf_pkg::HALF_BIT] = sum5[4];
      end
   end

   // Arithmetic flags: a software write takes priority over a same-cycle update.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         arith_reg <= csf_pkg::RESET_VALUE[7:2];
      end else if (sel_wr) begin
         // RULE_12: write wins
         arith_reg <= REG_WDATA[7:2];
      end else if (OP_VALID && op != csf_pkg::CSF_OP_NONE) begin
         arith_reg <= flags_next[7:2];
      end
   end

   // Fast service status follows the interrupt controller only; writes are ignored.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         // RULE_11: reset clears status
         fast_reg <= csf_pkg::RESET_VALUE[csf_pkg::FAST_BIT];
      end else if (FAST_RETURN) begin
         // RULE_08: return clears status
         fast_reg <= 1'b0;
      end else if (FAST_ENTER) begin
         // RULE_07: fast service sets
         fast_reg <= 1'b1;
      end
   end

   // Bank select is plain software state.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         // RULE_11: reset clears bank
         bank_reg <= csf_pkg::RESET_VALUE[csf_pkg::BANK_BIT];
      end else if (sel_wr) begin
         // RULE_09: bank write
         bank_reg <= REG_WDATA[csf_pkg::BANK_BIT];
      end
   end

   // Registered outputs; a read returns the value held before this edge.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= 8'h00;
         REG_HIT <= 1'b0;
         RESULT <= 8'h00;
         BANK_SEL <= 1'b0;
      end else begin
         REG_HIT <= sel_rd;
         REG_RDATA <= sel_rd ? flags_reg : 8'h00;
         RESULT <= (OP_VALID && op != csf_pkg::CSF_OP_NONE) ? res : RESULT;
         BANK_SEL <= sel_wr ? REG_WDATA[csf_pkg::BANK_BIT] : flags_reg[csf_pkg::BANK_BIT];
      end
   end

   // Checks on the flag behaviour.
   sequence s_add_op;
      OP_VALID && !sel_wr && op == csf_pkg::CSF_OP_ADD;
   endsequence
   sequence s_sub_op;
      OP_VALID && !sel_wr && op == csf_pkg::CSF_OP_SUB;
   endsequence

   a_carry_add: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_01
      s_add_op |=> flags_reg[7] == ($past({1'b0, OP_A}) + $past({1'b0, OP_B})
         + {8'h00, $past(OP_CARRY_IN)} > 9'h0FF))
      else $error("Carry wrong after add.");
   a_zero_flag: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_02
      (s_add_op or s_sub_op) |=> flags_reg[6] == (RESULT == 8'h00))
      else $error("Zero flag disagrees with result.");
   a_sign_flag: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_03
      (s_add_op or s_sub_op) |=> flags_reg[5] == RESULT[7])
      else $error("Sign flag disagrees with result.");
   a_ovfl_add: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_04
      s_add_op |=> flags_reg[4] == ($past(OP_A[7]) == $past(OP_B[7])
         && RESULT[7] != $past(OP_A[7])))
      else $error("Overflow wrong after add.");
   a_dec_kind: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_05
      s_sub_op |=> flags_reg[3])
      else $error("Decimal flag not set after subtract.");
   a_half_add: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_06
      s_add_op |=> flags_reg[2] == ({1'b0, $past(OP_A[3:0])} + {1'b0, $past(OP_B[3:0])}
         + {4'h0, $past(OP_CARRY_IN)} > 5'h0F))
      else $error("Half-carry wrong after add.");
   a_fast_set: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_07
      FAST_ENTER && !FAST_RETURN |=> flags_reg[1])
      else $error("Fast status not set.");
   a_fast_ret: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_08
      FAST_RETURN |=> !flags_reg[1])
      else $error("Fast status not cleared on return.");
   a_bank_out: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_09
      sel_wr |=> BANK_SEL == $past(REG_WDATA[0]))
      else $error("Bank select not following write.");
   a_indirect_none: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_10
      REG_WR && !REG_DIRECT && !OP_VALID |=> $stable(flags_reg[7:2]) && $stable(flags_reg[0]))
      else $error("Indirect write changed register.");
   a_write_wins: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_12
      sel_wr |=> flags_reg[7:2] == $past(REG_WDATA[7:2]))
      else $error("Written flags overridden.");
   a_carry_sub: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_01
      s_sub_op |=> flags_reg[7] == ({1'b0, $past(OP_A)}
         < {1'b0, $past(OP_B)} + {8'h00, $past(OP_CARRY_IN)}))
      else $error("Carry wrong after subtract.");
   a_half_sub: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_06
      s_sub_op |=> flags_reg[2] == ({1'b0, $past(OP_A[3:0])}
         < {1'b0, $past(OP_B[3:0])} + {4'h0, $past(OP_CARRY_IN)}))
      else $error("Half-carry wrong after subtract.");
   a_read_data: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_10
      sel_rd |=> REG_HIT && REG_RDATA == $past(flags_reg))
      else $error("Direct read did not return the register.");
   a_bank_match: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_09
      BANK_SEL == flags_reg[csf_pkg::BANK_BIT])
      else $error("Bank select differs from the register bit.");
endmodule
`default_nettype wire

// ===== rtl/csf_pkg.sv
package csf_pkg;
   // Register address of the condition state register in the register file.
   localparam logic [7:0] CPU_CONDITION_STATE_ADDR = 8'hD5;
   // Bit positions inside the register.
   localparam int CARRY_BIT = 7;
   localparam int ZERO_BIT = 6;
   localparam int SIGN_BIT = 5;
   localparam int OVFL_BIT = 4;
   localparam int DEC_BIT = 3;
   localparam int HALF_BIT = 2;
   localparam int FAST_BIT = 1;
   localparam int BANK_BIT = 0;
   // Reset value of the two control bits; the arithmetic flags start at zero here.
   localparam logic [7:0] RESET_VALUE = 8'h00;
   // Operation kinds presented by the datapath.
   typedef enum logic [1:0] {
      CSF_OP_NONE,
      CSF_OP_ADD,
      CSF_OP_SUB,
      CSF_OP_LOGIC
   } csf_op_t;
endpackage

// ===== bench/csf_status_flags_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module csf_status_flags_tb_top;
   logic clk = 0, rst_n = 0, ci = 0, valid = 0, fen = 0, fret = 0, wr = 0, rd = 0, dir = 0;
   logic [1:0] kind = 0; // Operation kind driven to the block.
   logic [7:0] a = 0, b = 0, wdata = 0, addr = 0; // Operand and register bus drives.
   logic [7:0] rdata, result; // Observed outputs.
   logic hit, bank; // Observed read strobe and bank select.
   logic [7:0] fl = 0, res = 0; // Reference flags and result kept by the bench.
   logic [7:0] q[$]; // Expected read values in issue order.
   localparam logic [7:0] AD = csf_pkg::CPU_CONDITION_STATE_ADDR;
   localparam logic [18:0] TAB [6] = '{{2'd1, 16'h7F_01, 1'b0}, {2'd1, 16'h0F_01, 1'b0},
      {2'd2, 16'h80_01, 1'b0}, {2'd2, 16'h10_01, 1'b1}, {2'd1, 16'hFF_00, 1'b1},
      {2'd3, 16'hF0_0F, 1'b0}}; // Boundary cases for carry, half, overflow and zero.
   int errors = 0, checked = 0, cycles = 0;
   always #12.5 clk = ~clk;
   csf_status_flags csf_status_flags_inst (.CLK(clk), .RST_N(rst_n), .OP_KIND(kind), .OP_A(a),
      .OP_B(b), .OP_CARRY_IN(ci), .OP_VALID(valid), .FAST_ENTER(fen), .FAST_RETURN(fret),
      .REG_WR(wr), .REG_RD(rd), .REG_DIRECT(dir), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .REG_HIT(hit), .RESULT(result), .BANK_SEL(bank));
   // Compares one value and counts the outcome.
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic results;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Lets the strobes be taken at one edge, then drops them off the edge.
   task automatic tick;
      @(posedge clk);
      #1;
      {valid, fen, fret, wr, rd} = 0;
   endtask
   // Presents an operation and advances the reference flags the same way.
   task automatic op(input logic [1:0] k, input logic [7:0] x, input logic [7:0] y, input logic c);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r;
      {valid, kind, a, b, ci} = {1'b1, k, x, y, c};
      s = 0;
      h = 0;
      r = res;
      if (k == csf_pkg::CSF_OP_ADD) begin
         s = x + y + c;
         h = x[3:0] + y[3:0] + c;
         fl[4:3] = {(x[7] == y[7]) && (s[7] != x[7]), 1'b0};
      end
      if (k == csf_pkg::CSF_OP_SUB) begin
         s = {1'b0, x} - y - c;
         h = {1'b0, x[3:0]} - y[3:0] - c;
         fl[4:3] = {(x[7] != y[7]) && (s[7] != x[7]), 1'b1};
      end
      if (k == csf_pkg::CSF_OP_ADD || k == csf_pkg::CSF_OP_SUB) begin
         {r, fl[7], fl[2]} = {s[7:0], s[8], h[4]};
      end
      if (k == csf_pkg::CSF_OP_LOGIC) {r, fl[4]} = {x & y, 1'b0};
      if (k != csf_pkg::CSF_OP_NONE) {fl[6], fl[5], res} = {r == 8'h00, r[7], r};
   endtask
   // Register write; only a direct access to the flag address changes the model.
   task automatic wrt(input logic [7:0] ad, input logic d, input logic [7:0] v);
      {wr, addr, dir, wdata} = {1'b1, ad, d, v};
      if (d && ad == AD) fl = {v[7:2], fl[1], v[0]};
   endtask
   // Register read; a hit is expected only for a direct access to the flag address.
   task automatic rdt(input logic [7:0] ad, input logic d);
      {rd, addr, dir} = {1'b1, ad, d};
      if (d && ad == AD) q.push_back(fl);
   endtask
   // Watches reads and cuts a hang short; a hit with nothing expected is a fault.
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         errors++;
         results;
      end
      if (hit === 1'b1) begin
         if (q.size() == 0) check("stray hit", 8'h01, 8'h00);
         else check("flags", rdata, q.pop_front());
      end
   end
   initial begin
      void'($urandom(21));
      repeat (3) @(posedge clk);
      #1 rst_n = 1;
      rdt(AD, 1);
      tick;
      // fast bit enter, read-only, return wins.
      fen = 1;
      fl[1] = 1;
      tick;
      wrt(AD, 1, 8'h00);
      tick;
      rdt(AD, 1);
      tick;
      {fen, fret, fl[1]} = 3'b110;
      tick;
      rdt(AD, 1);
      tick;
      wrt(AD, 1, 8'hFF);
      tick;
      check("bank", {7'h00, bank}, 8'h01);
      wrt(AD, 0, 8'h00);
      tick;
      wrt(8'hD4, 1, 8'h00);
      tick;
      rdt(AD, 0);
      tick;
      rdt(8'hD6, 1);
      tick;
      op(2'd1, 8'hFF, 8'h01, 1'b0);
      wrt(AD, 1, 8'h54);
      tick;
      rdt(AD, 1);
      tick;
      for (int i = 0; i < 66; i++) begin
         if (i < 6) op(TAB[i][18:17], TAB[i][16:9], TAB[i][8:1], TAB[i][0]);
         else op(2'($urandom_range(3, 0)), 8'($urandom), 8'($urandom), 1'($urandom));
         tick;
         check("result", result, res);
         rdt(AD, 1);
         tick;
      end
      // second reset in mid-run, with both control bits set first.
      {fen, fl[1]} = 2'b11;
      wrt(AD, 1, 8'h01);
      tick;
      check("bank before reset", {7'h00, bank}, 8'h01);
      rst_n = 0;
      tick;
      {rst_n, fl, res} = {1'b1, 16'h0000};
      check("bank reset", {7'h00, bank}, 8'h00);
      check("result reset", result, res);
      rdt(AD, 1);
      tick;
      tick;
      check("pending reads", 8'(q.size()), 8'h00);
      results;
   end
endmodule
`default_nettype wire
